/* File: logic/sar_adc_pkg.sv */
// Shared constants for the SAR converter sequencer
package sar_adc_pkg;
    localparam logic [7:0] ADDR_MODE      = 8'h00;
    localparam logic [7:0] ADDR_START     = 8'h04;
    localparam logic [7:0] ADDR_RESULT    = 8'h08;
    localparam logic [7:0] ADDR_STATUS    = 8'h0C;
    localparam logic [7:0] ADDR_MASK      = 8'h10;
    localparam int         MODE_SPEED_BIT = 7;
    localparam int         MODE_TRIG_BIT  = 6;
    localparam logic [1:0] MODE_RSVD_ONES = 2'h3;
    localparam logic [7:0] MODE_RESET     = 8'h30;
    localparam int         START_BUSY_BIT = 7;
    localparam logic [6:0] START_RSVD     = 7'h7F;
    localparam int         STATUS_END_BIT = 0;
    localparam logic [1:0] CHAN_GROUP_LOW = 2'h1;
    localparam logic [1:0] CHAN_GROUP_HI  = 2'h2;
    localparam int         SLOW_CYCLES    = 62;
    localparam int         FAST_CYCLES    = 31;
    localparam logic [3:0] SLOW_STEP      = 4'h7;
    localparam logic [3:0] FAST_STEP      = 4'h3;
    localparam logic [3:0] SLOW_SAMPLE    = 4'(SLOW_CYCLES - 8 * 7);
    localparam logic [3:0] FAST_SAMPLE    = 4'(FAST_CYCLES - 8 * 3);
    typedef enum logic [1:0] {
        SAR_IDLE    = 2'b00,
        SAR_SAMPLE  = 2'b01,
        SAR_CONVERT = 2'b10
    } sar_state_t;
endpackage

/* File: logic/sar_adc_sequencer.sv */
// AHB-Lite register file and sequencing for the eight-channel SAR converter
//
// The implementer's own choices: the register addresses and the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
// Function
// - Result register is 8-bit read-only and holds until the next completion.
// - Reset leaves the result register untouched; reads allowed at any time.
// - Mode register resets to 0x30.
// - Mode bit 7 picks 62 cycles (zero) or 31 cycles (one) per conversion.
// - Mode bit 6 enables the trigger pin; at zero the pin is ignored.
// - Mode bits 5 and 4 read as one and ignore writes.
// - Channel field: 00xx none, 01xx inputs 0-3, 10xx inputs 4-7, 11xx reserved.
// - Writing one to start bit 7 launches; writing zero stops a conversion.
// - Busy reads one during conversion and clears as the result loads.
// - An enabled trigger edge sets busy and starts like a software start.
// - Each completion sets the end flag; interrupt only when enabled.
// - Start register bits 6 to 0 read as one and ignore writes.
// - Conversion is successive approximation giving one unsigned 8-bit code.
// - After completion the converter idles until busy is set again.
module sar_adc_sequencer
    import sar_adc_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        reset,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    output logic             irq,
    input  wire logic        trigger_pin,
    input  wire logic        trigger_edge_select,
    input  wire logic        comparator_pin,
    output logic      [7:0]  ladder_code,
    output logic      [7:0]  channel_enable,
    output logic             sample_enable
);
    sar_link sar ();

    logic       speed_select;
    logic       ext_trigger_enable;
    logic [3:0] channel_sel;
    logic       start_busy_flag;
    logic [7:0] conversion_result;
    logic [0:0] irq_status;
    logic [0:0] irq_mask;
    logic [0:0] next_status;
    logic [7:0] mode_rd;
    logic [7:0] start_rd;
    logic       wr_pend;
    logic [7:0] wr_addr;
    logic       addr_ok;
    logic [2:0] trig_sync;
    logic       trig_level;
    logic       trig_edge;
    logic       wr_start_reg;
    logic       sw_start;
    logic       hw_start;
    logic [7:0] conv_cycles;
    logic [7:0] chan_dec;

    sar_engine engine (
        .clock (clock),
        .reset (reset),
        .sar   (sar.engine)
    );

    assign addr_ok  = hsel && htrans[1] && hready;
    assign mode_rd  = {speed_select, ext_trigger_enable, MODE_RSVD_ONES, channel_sel};
    assign start_rd = {start_busy_flag, START_RSVD};

    // Bus slave: zero wait states, always OKAY
    always_ff @(posedge clock) begin
        if (reset) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // Writes land in the data phase
    always_ff @(posedge clock) begin
        if (reset) begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
        end else begin
            wr_pend <= addr_ok && hwrite;
            wr_addr <= haddr[7:0];
        end
    end

    // Read data captured at the address phase
    always_ff @(posedge clock) begin
        if (reset) begin
            hrdata <= 32'h0000_0000;
        end else if (addr_ok && !hwrite) begin
            case (haddr[7:0])
                ADDR_MODE:   hrdata <= {24'h00_0000, mode_rd};
                ADDR_START:  hrdata <= {24'h00_0000, start_rd};
                ADDR_RESULT: hrdata <= {24'h00_0000, conversion_result};
                ADDR_STATUS: hrdata <= {31'h0000_0000, irq_status};
                ADDR_MASK:   hrdata <= {31'h0000_0000, irq_mask};
                default:     hrdata <= 32'h0000_0000;
            endcase
        end
    end

    assign wr_start_reg = wr_pend && (wr_addr == ADDR_START);

    // Mode register
    always_ff @(posedge clock) begin
        if (reset) begin
            speed_select       <= MODE_RESET[MODE_SPEED_BIT];
            ext_trigger_enable <= MODE_RESET[MODE_TRIG_BIT];
            channel_sel        <= MODE_RESET[3:0];
        end else if (wr_pend && wr_addr == ADDR_MODE) begin
            speed_select       <= hwdata[MODE_SPEED_BIT];
            ext_trigger_enable <= hwdata[MODE_TRIG_BIT];
            channel_sel        <= hwdata[3:0];
        end
    end

    // Trigger pin: three stages, level accepted when stages two and three agree
    always_ff @(posedge clock) begin
        if (reset) begin
            trig_sync  <= 3'h0;
            trig_level <= 1'b0;
        end else begin
            trig_sync <= {trig_sync[1:0], trigger_pin};
            if (trig_sync[1] == trig_sync[2]) begin
                trig_level <= trig_sync[2];
            end
        end
    end

    assign trig_edge = (trig_sync[1] == trig_sync[2]) && (trig_sync[2] != trig_level)
                       && (trig_sync[2] == trigger_edge_select);

    // Start requests only count while idle
    assign sw_start  = wr_start_reg && hwdata[START_BUSY_BIT] && !start_busy_flag;
    assign hw_start  = ext_trigger_enable && trig_edge && !start_busy_flag;
    assign sar.start = sw_start || hw_start;
    assign sar.abort = wr_start_reg && !hwdata[START_BUSY_BIT] && start_busy_flag
                       && !sar.done;
    assign sar.fast  = speed_select;
    // Comparator runs on this clock; a synchroniser would outlast the three-cycle fast step
    assign sar.comp_high = comparator_pin;

    // Busy flag and result register
    always_ff @(posedge clock) begin
        if (reset) begin
            start_busy_flag <= 1'b0;
        end else if (sar.done) begin
            start_busy_flag <= 1'b0;
        end else if (sar.start) begin
            start_busy_flag <= 1'b1;
        end else if (sar.abort) begin
            start_busy_flag <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (sar.done) begin
            conversion_result <= sar.result;
        end
    end

    // Interrupt status: completion sets, status read clears, set wins
    always_comb begin
        next_status = irq_status;
        if (addr_ok && !hwrite && haddr[7:0] == ADDR_STATUS) begin
            next_status = 1'b0;
        end
        if (sar.done) begin
            next_status[STATUS_END_BIT] = 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            irq_status <= 1'b0;
            irq_mask   <= 1'b0;
            irq        <= 1'b0;
        end else begin
            irq_status <= next_status;
            if (wr_pend && wr_addr == ADDR_MASK) begin
                irq_mask <= hwdata[0:0];
            end
            irq <= |(next_status & irq_mask);
        end
    end

    // Analog side controls
    always_comb begin
        chan_dec = 8'h00;
        if (channel_sel[3:2] == CHAN_GROUP_LOW) begin
            chan_dec = 8'h01 << channel_sel[1:0];
        end else if (channel_sel[3:2] == CHAN_GROUP_HI) begin
            chan_dec = 8'h10 << channel_sel[1:0];
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            ladder_code    <= 8'h00;
            channel_enable <= 8'h00;
            sample_enable  <= 1'b0;
        end else begin
            ladder_code    <= sar.ladder;
            channel_enable <= chan_dec;
            sample_enable  <= sar.active;
        end
    end

    // Cycle count of the running conversion, checking only
    always_ff @(posedge clock) begin
        if (reset || sar.start) begin
            conv_cycles <= 8'h00;
        end else if (start_busy_flag) begin
            conv_cycles <= conv_cycles + 8'h01;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    chk_mode_reset_value: assert property (reset |=> mode_rd == MODE_RESET)
        else $error("Mode register not at reset value");

    chk_result_survives_reset: assert property (disable iff (1'b0)
        (reset && !sar.done) |=> $stable(conversion_result))
        else $error("Result register changed during reset");

    chk_result_hold: assert property (!$stable(conversion_result) |-> $past(sar.done))
        else $error("Result register changed without a completion");

    chk_done_clears_busy: assert property (sar.done |=>
        (!start_busy_flag && conversion_result == $past(sar.result) && irq_status[0]))
        else $error("Completion did not clear busy and load result");

    chk_conv_period: assert property (sar.done |->
        conv_cycles == (speed_select ? 8'(FAST_CYCLES) : 8'(SLOW_CYCLES)))
        else $error("Conversion period wrong");

    chk_reserved_ones: assert property (mode_rd[5:4] == 2'b11 && start_rd[6:0] == 7'h7F)
        else $error("Reserved bits not read as one");

    chk_sw_start_busy: assert property (sw_start |=> start_busy_flag ##1 sar.active)
        else $error("Software start did not start a conversion");

    chk_trigger_start: assert property (hw_start |=> start_busy_flag && sar.active)
        else $error("Trigger edge did not start a conversion");

    chk_trigger_gated: assert property ((!ext_trigger_enable && !start_busy_flag && !sw_start)
        |=> !start_busy_flag)
        else $error("Trigger pin started a conversion while disabled");

    chk_abort_no_end: assert property (sar.abort |=> (!sar.done && !start_busy_flag)[*4])
        else $error("Aborted conversion completed");

    chk_busy_no_restart: assert property (start_busy_flag |-> !sar.start)
        else $error("Start accepted while busy");

    chk_idle_after_done: assert property ((sar.done && !sar.start) |=> !sar.active)
        else $error("Engine not idle after completion");

    chk_irq_enable: assert property (sar.done |=> (irq == irq_mask[0]))
        else $error("Interrupt not gated by enable");

    chk_channel_decode: assert property ((channel_sel == 4'hA)[*2] |-> channel_enable == 8'h40)
        else $error("Channel decode wrong");

    chk_channel_none: assert property ((channel_sel[3:2] == 2'b00)[*2]
        |-> channel_enable == 8'h00)
        else $error("Channel enabled with no channel selected");

    chk_busy_needs_start: assert property ($rose(start_busy_flag) |-> $past(sar.start))
        else $error("Busy flag rose without a start request");

    chk_busy_tracks_engine: assert property (start_busy_flag |-> (sar.active || sar.done))
        else $error("Busy flag set while the engine is idle");

    chk_idle_means_clear: assert property (!start_busy_flag |-> !sar.active)
        else $error("Engine running while busy flag is clear");

    chk_done_needs_busy: assert property (sar.done |-> start_busy_flag)
        else $error("Completion without a running conversion");

    chk_busy_holds: assert property ((start_busy_flag && !sar.done && !sar.abort)
        |=> start_busy_flag)
        else $error("Busy flag dropped during a conversion");

    chk_done_one_cycle: assert property (sar.done |=> !sar.done)
        else $error("Completion pulse longer than one cycle");

    chk_ladder_idle: assert property (!sar.active |=> ladder_code == 8'h00)
        else $error("Ladder code not cleared while idle");

    chk_abort_keeps_result: assert property (sar.abort |=> $stable(conversion_result))
        else $error("Aborted conversion changed the result");

    chk_abort_no_flag: assert property ((sar.abort && !irq_status[0]) |=> !irq_status[0])
        else $error("Aborted conversion set the end flag");

    chk_zero_write_idle: assert property ((wr_start_reg && !hwdata[START_BUSY_BIT]
        && !start_busy_flag && !hw_start) |=> !start_busy_flag)
        else $error("Writing zero while idle set the busy flag");

    chk_status_read_clears: assert property ((addr_ok && !hwrite
        && haddr[7:0] == ADDR_STATUS && !sar.done) |=> !irq_status[0])
        else $error("Status read did not clear the end flag");

    chk_irq_level: assert property ($stable(irq_mask) |-> irq == |(irq_status & irq_mask))
        else $error("Interrupt level disagrees with status and mask");

    chk_result_readback: assert property ((addr_ok && !hwrite
        && haddr[7:0] == ADDR_RESULT) |=> hrdata == {24'h00_0000, $past(conversion_result)})
        else $error("Result read returned the wrong value");

    chk_read_upper_zero: assert property ((addr_ok && !hwrite) |=> hrdata[31:8] == 24'h00_0000)
        else $error("Upper read data bits not zero");

    chk_mode_reserved_write: assert property ((wr_pend && wr_addr == ADDR_MODE
        && hwdata[3:0] == 4'hF) |=> (channel_sel == 4'hF && mode_rd[5:4] == MODE_RSVD_ONES))
        else $error("Mode write did not land as expected");
endmodule // sar_adc_sequencer
`default_nettype wire

/* File: logic/sar_engine.sv */
// Successive approximation engine: sample phase then eight bit trials
`timescale 1ns/1ps
`default_nettype none
module sar_engine
    import sar_adc_pkg::*;
(
    input  wire logic clock,
    input  wire logic reset,
    sar_link.engine   sar
);
    sar_state_t state;
    logic [3:0] cnt;
    logic [2:0] bit_idx;
    logic       fast;
    logic [7:0] trial;
    logic [7:0] kept;

    always_comb begin
        kept = trial;
        if (!sar.comp_high) begin
            kept[bit_idx] = 1'b0;
        end
    end

    assign sar.active = (state != SAR_IDLE);
    assign sar.ladder = trial;

    always_ff @(posedge clock) begin
        sar.done <= 1'b0;
        if (reset) begin
            state   <= SAR_IDLE;
            cnt     <= 4'h0;
            bit_idx <= 3'h7;
            fast    <= 1'b0;
            trial   <= 8'h00;
            sar.result <= 8'h00;
        end else if (sar.abort) begin
            state <= SAR_IDLE;
            trial <= 8'h00;
        end else begin
            case (state)
                SAR_IDLE: begin
                    if (sar.start) begin
                        state <= SAR_SAMPLE;
                        cnt   <= 4'h0;
                        fast  <= sar.fast;
                        trial <= 8'h00;
                    end
                end
                SAR_SAMPLE: begin
                    cnt <= cnt + 4'h1;
                    if (cnt == (fast ? FAST_SAMPLE : SLOW_SAMPLE) - 4'h1) begin
                        state   <= SAR_CONVERT;
                        cnt     <= 4'h0;
                        bit_idx <= 3'h7;
                        trial   <= 8'h80;
                    end
                end
                SAR_CONVERT: begin
                    cnt <= cnt + 4'h1;
                    if (cnt == (fast ? FAST_STEP : SLOW_STEP) - 4'h1) begin
                        cnt <= 4'h0;
                        if (bit_idx == 3'h0) begin
                            state      <= SAR_IDLE;
                            sar.done   <= 1'b1;
                            sar.result <= kept;
                            trial      <= 8'h00;
                        end else begin
                            bit_idx <= bit_idx - 3'h1;
                            trial   <= kept | (8'h01 << (bit_idx - 3'h1));
                        end
                    end
                end
                default: begin
                    state <= SAR_IDLE;
                end
            endcase
        end
    end

    chk_sar_trial_bits: assert property (@(posedge clock) disable iff (reset)
        (state == SAR_CONVERT) |-> ((trial & ((8'h01 << bit_idx) - 8'h01)) == 8'h00))
        else $error("Bits below the trial bit are not clear");
endmodule // sar_engine
`default_nettype wire

/* File: logic/sar_link.sv */
// Control link between the sequencer and the approximation engine
`timescale 1ns/1ps
`default_nettype none
interface sar_link;
    logic       start;
    logic       abort;
    logic       fast;
    logic       comp_high;
    logic       done;
    logic       active;
    logic [7:0] result;
    logic [7:0] ladder;
    modport ctrl   (output start, abort, fast, comp_high, input done, active, result, ladder);
    modport engine (input start, abort, fast, comp_high, output done, active, result, ladder);
endinterface
`default_nettype wire

/* File: verification/analog_source.sv */
// Behavioural analog inputs and comparator facing the converter
`timescale 1ns/1ps
`default_nettype none
module analog_source #(
    parameter logic [63:0] LEVELS = 64'h0
) (
    input  wire logic [7:0] ladder_code,
    input  wire logic [7:0] channel_enable,
    output logic            comparator_pin
);
    logic [7:0] level;
    // Ideal source settles at once, so any conversion period reads true
    always_comb begin
        level = 8'h00;
        for (int k = 0; k < 8; k++) begin
            if (channel_enable[k]) begin
                level = LEVELS[k*8 +: 8];
            end
        end
    end
    // Unselected mux reads as ground, so the comparator stays low
    assign comparator_pin = (channel_enable == 8'h00) ? 1'b0 : (level >= ladder_code);
endmodule // analog_source
`default_nettype wire

/* File: verification/tb_top.sv */
// Self-checking bench for the SAR converter sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import sar_adc_pkg::*;
    localparam logic [63:0] VIN = 64'h3CC37F8001FF5AA5;
    logic        clock = 1'b0;
    logic        reset = 1'b1;
    logic        hsel = 1'b1;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic        hready;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        irq;
    logic        trigger_pin = 1'b0;
    logic        trigger_edge_select = 1'b1;
    logic        comparator_pin;
    logic [7:0]  ladder_code;
    logic [7:0]  channel_enable;
    logic        sample_enable;
    logic        se_prev = 1'b0;
    int          run_len = 0;
    logic [7:0]  chan_seen = 8'h00;
    int          err_total = 0;
    int          n_tests = 0;
    logic [31:0] rd;
    logic [7:0]  mode;
    logic [7:0]  en;
    logic [7:0]  expv;
    int          i;
    assign hready = hreadyout;
    always #10 clock = ~clock;
    sar_adc_sequencer dut (.clock(clock), .reset(reset), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq(irq),
        .trigger_pin(trigger_pin), .trigger_edge_select(trigger_edge_select),
        .comparator_pin(comparator_pin), .ladder_code(ladder_code),
        .channel_enable(channel_enable), .sample_enable(sample_enable));
    analog_source #(.LEVELS(VIN)) source (.ladder_code(ladder_code),
        .channel_enable(channel_enable), .comparator_pin(comparator_pin));
    // Length and channel of the latest conversion
    always @(posedge clock) begin
        se_prev <= sample_enable;
        if (sample_enable === 1'b1) begin
            run_len <= (se_prev === 1'b1) ? run_len + 1 : 1;
            chan_seen <= channel_enable;
        end
    end
    task automatic give_verdict();
        if (err_total == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            $display("wrong value %s expected %h seen %h", what, exp, got);
            err_total++;
        end
    endtask
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                        output logic [31:0] q);
        @(posedge clock);
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge clock); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        do @(posedge clock); while (hready !== 1'b1);
        q = hrdata;
    endtask
    task automatic expect_reg(input string what, input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        xfer(1'b0, a, 8'h00, q);
        check(what, e, q);
        check("response", 32'h0, {31'h0, hresp});
    endtask
    task automatic wait_done(input logic [7:0] e_en, input int e_len);
        logic seen;
        seen = 1'b0;
        for (int k = 0; k < 300 && !seen; k++) begin
            @(posedge clock);
            seen = (se_prev === 1'b1 && sample_enable === 1'b0);
        end
        check("conversion end", 32'h1, {31'h0, seen});
        check("conversion length", e_len, run_len);
        check("channel enable", e_en, chan_seen);
    endtask
    initial begin
        repeat (30000) @(posedge clock);
        err_total++;
        give_verdict();
    end
    initial begin
        repeat (16) @(posedge clock);
        reset <= 1'b0;
        expect_reg("mode reset", ADDR_MODE, 32'h30);
        expect_reg("start reset", ADDR_START, 32'h7F);
        expect_reg("status reset", ADDR_STATUS, 32'h0);
        expect_reg("unmapped", 8'h20, 32'h0);
        xfer(1'b1, ADDR_START, 8'h00, rd);
        expect_reg("start idle", ADDR_START, 32'h7F);
        xfer(1'b1, ADDR_MODE, 8'h0F, rd);
        expect_reg("mode reserved", ADDR_MODE, 32'h3F);
        xfer(1'b1, ADDR_MASK, 8'h01, rd);
        for (i = 0; i < 10; i++) begin
            mode = (i < 8) ? 8'(8'h84 + i) : ((i == 8) ? 8'h80 : 8'h8C);
            en = (i < 8) ? 8'(1 << i) : 8'h00;
            expv = (i < 8) ? VIN[i*8 +: 8] : 8'h00;
            xfer(1'b1, ADDR_MODE, mode, rd);
            xfer(1'b1, ADDR_START, 8'h80, rd);
            wait_done(en, FAST_CYCLES);
            check("irq set", 1'b1, irq);
            expect_reg("status", ADDR_STATUS, 32'h1);
            @(posedge clock);
            check("irq cleared", 1'b0, irq);
            expect_reg("result", ADDR_RESULT, {24'h0, expv});
        end
        xfer(1'b1, ADDR_MODE, 8'h05, rd);
        xfer(1'b1, ADDR_START, 8'h80, rd);
        expect_reg("busy", ADDR_START, 32'hFF);
        xfer(1'b1, ADDR_START, 8'h80, rd);
        wait_done(8'h02, SLOW_CYCLES);
        expect_reg("busy clear", ADDR_START, 32'h7F);
        expect_reg("result slow", ADDR_RESULT, {24'h0, VIN[15:8]});
        reset <= 1'b1;
        repeat (16) @(posedge clock);
        reset <= 1'b0;
        expect_reg("result kept", ADDR_RESULT, {24'h0, VIN[15:8]});
        expect_reg("mode again", ADDR_MODE, 32'h30);
        xfer(1'b1, ADDR_MODE, 8'h06, rd);
        xfer(1'b1, ADDR_START, 8'h80, rd);
        repeat (10) @(posedge clock);
        xfer(1'b1, ADDR_START, 8'h00, rd);
        repeat (80) @(posedge clock);
        check("idle after abort", 1'b0, sample_enable);
        check("irq after abort", 1'b0, irq);
        expect_reg("status abort", ADDR_STATUS, 32'h0);
        expect_reg("result abort", ADDR_RESULT, {24'h0, VIN[15:8]});
        xfer(1'b1, ADDR_MODE, 8'h87, rd);
        trigger_pin <= 1'b1;
        repeat (10) @(posedge clock);
        expect_reg("trigger off", ADDR_START, 32'h7F);
        trigger_pin <= 1'b0;
        repeat (10) @(posedge clock);
        xfer(1'b1, ADDR_MODE, 8'hC7, rd);
        trigger_pin <= 1'b1;
        wait_done(8'h08, FAST_CYCLES);
        check("irq masked", 1'b0, irq);
        expect_reg("status trig", ADDR_STATUS, 32'h1);
        expect_reg("result trig", ADDR_RESULT, {24'h0, VIN[31:24]});
        trigger_edge_select <= 1'b0;
        repeat (10) @(posedge clock);
        trigger_pin <= 1'b0;
        wait_done(8'h08, FAST_CYCLES);
        repeat (40) @(posedge clock);
        check("stays idle", 1'b0, sample_enable);
        give_verdict();
    end
endmodule // tb_top
`default_nettype wire
